// >>> verilog/timer_b_pkg.sv
// Package for the type B timer register tail: offsets, reset values,
// counter modes and the bundles that carry the register bus and core inputs.
// Assumes one system clock; every user is on that clock.
package timer_b_pkg;

    // Byte offsets within the timer's register window
    localparam logic [3:0] OFS_STATUS     = 4'h7;
    localparam logic [3:0] OFS_DEBUG_RUN  = 4'h8;
    localparam logic [3:0] OFS_LATCH      = 4'h9;
    localparam logic [3:0] OFS_COUNT      = 4'ha;
    localparam logic [3:0] OFS_COMPARE    = 4'hc;
    localparam logic [3:0] OFS_HIGH_STEP  = 4'h1;

    // Field positions
    localparam int         RUN_BIT        = 0;
    localparam int         DEBUG_RUN_BIT  = 0;

    // Values after reset
    localparam logic [7:0]  LATCH_RESET   = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic        DEBUG_RESET   = 1'b0;
    localparam logic [7:0]  READ_ZERO     = 8'h00;

    typedef enum logic [2:0] {
        MODE_PERIODIC,
        MODE_TIMEOUT,
        MODE_CAPT_EVENT,
        MODE_CAPT_FREQ,
        MODE_CAPT_PULSE,
        MODE_CAPT_FREQ_PULSE,
        MODE_SINGLE_SHOT,
        MODE_PWM8
    } count_mode_t;

    // Byte-wide register access from the processor or the debug interface
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    // Same-clock strobes and levels from the timer core
    typedef struct packed {
        count_mode_t mode;
        logic        counter_on;
        logic        tick;
        logic        restart;
        logic        capture;
    } core_in_t;

endpackage

// >>> verilog/timer_b_counter_compare_regs.sv
// Type B timer count, capture/compare and shared byte latch, plus debug run.
// Assumes byte-wide bus requests and core strobes on clk, and a cpu_halted
// level from the debug logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Debug run clear: timer freezes and ignores events while processor is halted.
// - Debug run set: timer keeps running normally while processor is halted.
// - One readable, writable byte latch is shared by count, and by compare outside 8-bit PWM mode.
// - Count low byte at its base offset, high byte at base plus one.
// - A bus write to the count beats the counter's own update.
// - Compare low byte at its base offset, high byte at base plus one.
// - In capture modes the compare register takes the count at capture.
// - Periodic, timeout and single-shot modes use compare as the top value.
// - In 8-bit PWM mode compare bytes are two independent byte registers.
// - Run status reads 1 while counting, 0 when stopped; read only.
module timer_b_counter_compare_regs (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire timer_b_pkg::bus_req_t  bus,
    input  wire timer_b_pkg::core_in_t  core,
    input  wire logic                   cpu_halted,
    output logic [7:0]                  rdata,
    output logic [15:0]                 count_value,
    output logic [15:0]                 capture_compare_value,
    output logic                        debug_run,
    output logic                        run_status,
    output logic                        top_match
);
    import timer_b_pkg::*;

    logic [7:0] byte_latch;
    logic       active;
    logic       pwm;
    logic       top_mode;
    logic       capt_mode;
    logic       at_top;
    logic       count_step;
    logic       cnt_lo_wr;
    logic       cnt_hi_wr;
    logic       cmp_lo_wr;
    logic       cmp_hi_wr;
    logic       cnt_lo_rd;
    logic       cmp_lo_rd;
    logic [7:0] next_rdata;

    // Halt gating: every core strobe below is qualified by this
    assign active    = !cpu_halted || debug_run;
    assign pwm       = (core.mode == MODE_PWM8);
    assign top_mode  = (core.mode == MODE_PERIODIC) || (core.mode == MODE_TIMEOUT)
                       || (core.mode == MODE_SINGLE_SHOT);
    assign capt_mode = (core.mode == MODE_CAPT_EVENT) || (core.mode == MODE_CAPT_FREQ)
                       || (core.mode == MODE_CAPT_PULSE)
                       || (core.mode == MODE_CAPT_FREQ_PULSE);
    // PWM wraps on the low compare byte only
    assign at_top    = pwm ? (count_value[7:0] == capture_compare_value[7:0])
                           : (top_mode && count_value == capture_compare_value);
    assign count_step = active && core.tick && core.counter_on;

    assign cnt_lo_wr = bus.wr && bus.addr == OFS_COUNT;
    assign cnt_hi_wr = bus.wr && bus.addr == OFS_COUNT + OFS_HIGH_STEP;
    assign cmp_lo_wr = bus.wr && bus.addr == OFS_COMPARE;
    assign cmp_hi_wr = bus.wr && bus.addr == OFS_COMPARE + OFS_HIGH_STEP;
    assign cnt_lo_rd = bus.rd && bus.addr == OFS_COUNT;
    assign cmp_lo_rd = bus.rd && bus.addr == OFS_COMPARE;

    // Debug run control bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            debug_run <= DEBUG_RESET;
        end else if (bus.wr && bus.addr == OFS_DEBUG_RUN) begin
            debug_run <= bus.wdata[DEBUG_RUN_BIT];
        end
    end

    // Shared latch; one register serves count, and compare outside PWM mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            byte_latch <= LATCH_RESET;
        end else if (bus.wr && bus.addr == OFS_LATCH) begin
            byte_latch <= bus.wdata;
        end else if (cnt_lo_wr || (cmp_lo_wr && !pwm)) begin
            byte_latch <= bus.wdata;
        end else if (cnt_lo_rd) begin
            byte_latch <= count_value[15:8];
        end else if (cmp_lo_rd && !pwm) begin
            byte_latch <= capture_compare_value[15:8];
        end
    end

    // Count; bus commit is checked first so it wins over the core
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_value <= COUNT_RESET;
        end else if (cnt_hi_wr) begin
            count_value <= {bus.wdata, byte_latch};
        end else if (active && core.restart) begin
            count_value <= COUNT_RESET;
        end else if (count_step && at_top) begin
            count_value <= COUNT_RESET;
        end else if (count_step) begin
            count_value <= count_value + 16'h0001;
        end
    end

    // Capture/compare register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_compare_value <= COMPARE_RESET;
        end else if (cmp_hi_wr && pwm) begin
            capture_compare_value[15:8] <= bus.wdata;
        end else if (cmp_hi_wr) begin
            capture_compare_value <= {bus.wdata, byte_latch};
        end else if (cmp_lo_wr && pwm) begin
            capture_compare_value[7:0] <= bus.wdata;
        end else if (active && core.capture && capt_mode) begin
            capture_compare_value <= count_value;
        end
    end

    // Status flags; run status has no write path at all
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_status <= 1'b0;
            top_match  <= 1'b0;
        end else begin
            run_status <= core.counter_on && active;
            top_match  <= count_step && at_top && !cnt_hi_wr;
        end
    end

    // Read mux; high count byte reads the latch so the pair stays atomic
    always_comb begin
        next_rdata = READ_ZERO;
        unique case (bus.addr)
            OFS_STATUS:    next_rdata[RUN_BIT] = run_status;
            OFS_DEBUG_RUN: next_rdata[DEBUG_RUN_BIT] = debug_run;
            OFS_LATCH:     next_rdata = byte_latch;
            OFS_COUNT:     next_rdata = count_value[7:0];
            OFS_COUNT + OFS_HIGH_STEP: next_rdata = byte_latch;
            OFS_COMPARE:   next_rdata = capture_compare_value[7:0];
            OFS_COMPARE + OFS_HIGH_STEP:
                next_rdata = pwm ? capture_compare_value[15:8] : byte_latch;
            default:       next_rdata = READ_ZERO;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= READ_ZERO;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    halt_freeze_a: assert property (
        (cpu_halted && !debug_run && !cnt_hi_wr) |=> $stable(count_value))
        else $error("count moved while halted without debug run");

    debug_keep_a: assert property (
        (cpu_halted && debug_run && core.tick && core.counter_on && !core.restart
         && !at_top && !cnt_hi_wr) |=> count_value == $past(count_value) + 16'h0001)
        else $error("count stalled while halted with debug run");

    latch_write_a: assert property (
        (bus.wr && bus.addr == OFS_LATCH) ##1 (bus.rd && bus.addr == OFS_LATCH)
        |=> rdata == $past(bus.wdata, 2))
        else $error("latch did not return written byte");

    pair_commit_a: assert property (
        cnt_lo_wr ##1 cnt_hi_wr |=> count_value == {$past(bus.wdata), $past(bus.wdata, 2)})
        else $error("count pair not committed from latch");

    count_layout_a: assert property (
        cnt_lo_rd |=> rdata == $past(count_value[7:0]))
        else $error("count low byte read wrong");

    write_wins_a: assert property (
        (cnt_hi_wr && count_step) |=> count_value == {$past(bus.wdata), $past(byte_latch)})
        else $error("core update beat the bus write");

    cmp_layout_a: assert property (
        cmp_lo_rd |=> rdata == $past(capture_compare_value[7:0]))
        else $error("compare low byte read wrong");

    capture_load_a: assert property (
        (active && core.capture && capt_mode && !cmp_hi_wr && !cmp_lo_wr)
        |=> capture_compare_value == $past(count_value))
        else $error("capture did not load the count");

    top_wrap_a: assert property (
        (count_step && top_mode && count_value == capture_compare_value
         && !cnt_hi_wr && !core.restart) |=> count_value == COUNT_RESET && top_match)
        else $error("count did not wrap at top");

    pwm_bytes_a: assert property (
        (pwm && cmp_lo_wr) |=> capture_compare_value[15:8] == $past(capture_compare_value[15:8]))
        else $error("pwm low write disturbed high byte");

    run_flag_a: assert property (
        ##1 run_status == $past(core.counter_on && (!cpu_halted || debug_run)))
        else $error("run status does not follow counter");

    stop_flag_a: assert property (
        !core.counter_on |=> !run_status)
        else $error("run status set while counter off");

    low_read_latch_a: assert property (
        cnt_lo_rd |=> byte_latch == $past(count_value[15:8]))
        else $error("low count read did not latch high byte");

    cmp_commit_a: assert property (
        (!pwm && cmp_hi_wr) |=> capture_compare_value == {$past(bus.wdata), $past(byte_latch)})
        else $error("compare pair not committed from latch");

    pwm_latch_a: assert property (
        (pwm && (cmp_lo_wr || cmp_hi_wr)) |=> $stable(byte_latch))
        else $error("pwm compare write touched the latch");

    halt_capture_a: assert property (
        (cpu_halted && !debug_run && !cmp_hi_wr && !cmp_lo_wr)
        |=> $stable(capture_compare_value))
        else $error("compare moved while halted without debug run");

endmodule

`default_nettype wire

// >>> tb/timer_b_bus_model.sv
// Processor side byte bus master for the timer register tail.
// Assumes the design samples the bus on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module timer_b_bus_model (
    input  wire logic             clk,
    input  wire logic [7:0]       rdata,
    output var timer_b_pkg::bus_req_t bus
);
    import timer_b_pkg::*;
    initial bus = '0;
    // Released lines show inverted values, so a stale sample cannot pass
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic get(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        d = rdata;
    endtask
    // Back to back pair: strobe stays up while address moves to the high byte
    task automatic put16(input logic [3:0] a, input logic [15:0] v);
        @(negedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v[7:0]};
        @(negedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a + OFS_HIGH_STEP, wdata: v[15:8]};
        @(negedge clk);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v[15:8]};
    endtask
endmodule
`default_nettype wire

// >>> tb/test_timer_b_counter_compare_regs.sv
// Self-checking bench for the type B timer register tail.
// Assumes one 200 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module test_timer_b_counter_compare_regs;
    import timer_b_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    bus_req_t   bus;
    core_in_t   core = '{mode: MODE_PERIODIC, default: 1'b0};
    logic       cpu_halted = 1'b0;
    logic [7:0] rdata;
    logic [15:0] count_value;
    logic [15:0] capture_compare_value;
    logic       debug_run;
    logic       run_status;
    logic       top_match;
    logic [7:0] v;
    int         n_mismatch = 0;
    int         total_checks = 0;
    always #2.5 clk = ~clk;
    timer_b_bus_model timer_b_bus_model_i (.clk(clk), .rdata(rdata), .bus(bus));
    timer_b_counter_compare_regs timer_b_counter_compare_regs_i (
        .clk(clk), .rst(rst), .bus(bus), .core(core), .cpu_halted(cpu_halted),
        .rdata(rdata), .count_value(count_value),
        .capture_compare_value(capture_compare_value), .debug_run(debug_run),
        .run_status(run_status), .top_match(top_match));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [3:0] a);
        timer_b_bus_model_i.get(a, v);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        timer_b_bus_model_i.put(a, d);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk);
            core.tick <= 1'b1;
        end
        @(negedge clk);
        core.tick <= 1'b0;
    endtask
    task automatic t_reset();
        rd(OFS_LATCH); chk(v, LATCH_RESET);
        rd(OFS_COUNT); chk(v, COUNT_RESET[7:0]);
        rd(OFS_COMPARE); chk(v, COMPARE_RESET[7:0]);
        rd(4'he); chk(v, READ_ZERO);
        chk(debug_run, DEBUG_RESET);
    endtask
    task automatic t_pair();
        timer_b_bus_model_i.put16(OFS_COUNT, 16'h1234);
        chk(count_value, 16'h1234);
        rd(OFS_COUNT); chk(v, 8'h34);
        rd(OFS_COUNT + OFS_HIGH_STEP); chk(v, 8'h12);
        wr(OFS_LATCH, 8'h5a);
        rd(OFS_LATCH); chk(v, 8'h5a);
    endtask
    task automatic t_status();
        wr(OFS_STATUS, 8'hff);
        rd(OFS_STATUS); chk(v, 8'h00);
        core.counter_on <= 1'b1;
        rd(OFS_STATUS); chk(v, 8'h01);
    endtask
    task automatic t_top();
        timer_b_bus_model_i.put16(OFS_COMPARE, 16'h0003);
        timer_b_bus_model_i.put16(OFS_COUNT, 16'h0000);
        ticks(4); chk(count_value, 16'h0000);
        chk(top_match, 1'b1);
        ticks(2); chk(count_value, 16'h0002);
        chk(top_match, 1'b0);
    endtask
    task automatic t_debug();
        cpu_halted <= 1'b1;
        ticks(3); chk(count_value, 16'h0002);
        chk(run_status, 1'b0);
        wr(OFS_DEBUG_RUN, 8'h01);
        ticks(1); chk(count_value, 16'h0003);
        chk(run_status, 1'b1);
        wr(OFS_DEBUG_RUN, 8'h00);
        cpu_halted <= 1'b0;
    endtask
    task automatic t_wins();
        core.mode <= MODE_CAPT_EVENT;
        core.tick <= 1'b1;
        // Tick stays high across the committing edge
        timer_b_bus_model_i.put16(OFS_COUNT, 16'h4000);
        core.tick <= 1'b0;
        chk(count_value, 16'h4000);
        @(negedge clk);
        core.capture <= 1'b1;
        @(negedge clk);
        core.capture <= 1'b0;
        chk(capture_compare_value, 16'h4000);
    endtask
    task automatic t_pwm();
        core.mode <= MODE_PWM8;
        wr(OFS_LATCH, 8'h99);
        wr(OFS_COMPARE, 8'h77);
        chk(capture_compare_value, 16'h4077);
        wr(OFS_COMPARE + OFS_HIGH_STEP, 8'h22);
        chk(capture_compare_value, 16'h2277);
        rd(OFS_LATCH); chk(v, 8'h99);
        rd(OFS_COMPARE + OFS_HIGH_STEP); chk(v, 8'h22);
    endtask
    task automatic strobe(input logic r, input logic c);
        @(negedge clk);
        core.restart <= r;
        core.capture <= c;
        @(negedge clk);
        core.restart <= 1'b0;
        core.capture <= 1'b0;
    endtask
    task automatic t_modes();
        core.mode <= MODE_SINGLE_SHOT;
        timer_b_bus_model_i.put16(OFS_COMPARE, 16'h0001);
        timer_b_bus_model_i.put16(OFS_COUNT, 16'h0000);
        ticks(3); chk(count_value, 16'h0001);
        core.mode <= MODE_TIMEOUT;
        ticks(2); chk(count_value, 16'h0001);
        core.mode <= MODE_CAPT_FREQ_PULSE;
        ticks(1);
        cpu_halted <= 1'b1;
        strobe(1'b1, 1'b1);
        chk(count_value, 16'h0002);
        chk(capture_compare_value, 16'h0001);
        cpu_halted <= 1'b0;
        strobe(1'b0, 1'b1);
        chk(capture_compare_value, 16'h0002);
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        repeat (2) @(negedge clk);
        rst <= 1'b0;
        t_reset();
        t_pair();
        t_status();
        t_top();
        t_debug();
        t_wins();
        t_pwm();
        t_modes();
        stop_test();
    end
endmodule
`default_nettype wire
